// File: bctme_regs.vh
`ifndef BCTME_REGS_VH
`define BCTME_REGS_VH
`define BCTME_ADDR_CTRL 5'h00
`define BCTME_ADDR_INSTR 5'h04
`define BCTME_ADDR_OPER 5'h08
`define BCTME_ADDR_STATE 5'h0c
`define BCTME_ADDR_PCSP 5'h10
`define BCTME_ADDR_TIMER 5'h14
`define BCTME_ADDR_INPUT 5'h18
`define BCTME_OP_NOP 5'h00
`define BCTME_OP_JUMP 5'h01
`define BCTME_OP_JUMPC 5'h02
`define BCTME_OP_JUMPNC 5'h03
`define BCTME_OP_JUMPF 5'h04
`define BCTME_OP_JUMPNF 5'h05
`define BCTME_OP_CALL 5'h06
`define BCTME_OP_EXIT 5'h07
`define BCTME_OP_TBLPAIR 5'h08
`define BCTME_OP_RDTIM 5'h09
`define BCTME_OP_WRTIM 5'h0a
`define BCTME_OP_LDTIM 5'h0b
`define BCTME_OP_TBLTIM 5'h0c
`define BCTME_OP_HALT 5'h0d
`define BCTME_OP_STATREG 5'h0e
`define BCTME_OP_STATIMM 5'h0f
`define BCTME_OP_CAF 5'h10
`define BCTME_PC_RESET 10'h000
`define BCTME_SP_RESET 3'h0
`define BCTME_TIMER_RESET 10'h000
`define BCTME_ROM_LAST 10'h3ff
`define BCTME_TIMER_DIV_SHORT 5'h08
`define BCTME_TIMER_DIV_LONG 5'h10
`endif

// File: bctme_core.v
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "bctme_regs.vh"
module bctme_core (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [9:0] rom_data,
  output reg [9:0] rom_addr,
  output reg internal_reset,
  output reg standby,
  output reg [3:0] release_select
);
  // Program memory is a single 1K page; ROM word comes back one cycle after rom_addr
  localparam ST_IDLE = 3'b001;
  localparam ST_CALL2 = 3'b010;
  localparam ST_FETCH = 3'b100;

  reg [2:0] state;
  reg [9:0] pc;
  reg [9:0] ret_store;
  reg [2:0] sp;
  reg carry_bit;
  reg match_flag;
  reg [9:0] timer;
  reg timer_div_sel;
  reg [3:0] acc;
  reg [3:0] bank0_reg_0;
  reg [3:0] bank1_reg_0;
  reg [3:0] status_in;
  reg [1:0] rom_page_select;
  reg [4:0] instr;
  reg [9:0] operand;
  reg [7:0] pair_out;
  reg [3:0] pair_sel;
  reg pend_timer;
  reg busy;
  reg [3:0] nib_out;
  reg aw_held;
  reg w_held;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  // Operand word carries a9 a7 a6 a5 a4 a8 a3 a2 a1 a0
  function [9:0] bctme_unscramble;
    input [9:0] w;
    begin
      bctme_unscramble = {w[9], w[4], w[8:5], w[3:0]};
    end
  endfunction

  // Immediate timer operand carries t1 t9..t6 t0 t5..t2
  function [9:0] bctme_timer_unscramble;
    input [9:0] w;
    begin
      bctme_timer_unscramble = {w[8:5], w[3:0], w[9], w[4]};
    end
  endfunction

  // Conditional jumps fall through past their operand word
  function [9:0] bctme_branch;
    input take;
    input [9:0] dest;
    input [9:0] fall;
    begin
      bctme_branch = take ? dest : fall;
    end
  endfunction

  function bctme_any_match;
    input [3:0] stat;
    input [3:0] mask;
    begin
      bctme_any_match = |(stat & mask);
    end
  endfunction

  wire [9:0] target = bctme_unscramble(operand);
  wire [9:0] pc_skip = pc + 10'h002;
  wire [9:0] pc_next1 = pc + 10'h001;
  wire [7:0] pair_zero = {bank1_reg_0, bank0_reg_0};
  wire [9:0] table_addr = {rom_page_select, pair_zero};
  wire [3:0] sp_inc = {1'b0, sp} + 4'h1;
  wire [3:0] sp_dec = {1'b0, sp} - 4'h1;
  // Three-bit stack: the fourth bit of the sum flags overflow or underflow
  wire sp_carry = sp_inc[3];
  wire sp_borrow = sp_dec[3];
  wire [3:0] timer_nib = operand[0] ? timer[9:6] : timer[5:2];
  // Interval in oscillator periods, for software to read back
  wire [14:0] timer_interval = ({5'h00, timer} + 15'h0001) *
    (timer_div_sel ? {10'h000, `BCTME_TIMER_DIV_LONG} : {10'h000, `BCTME_TIMER_DIV_SHORT});

  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire exec_go = wr_go && (aw_addr == `BCTME_ADDR_CTRL) && w_data[0] && !busy && !standby;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Read word is decoded ahead of the register so rdata only moves on a new address
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = 2'b00;
    case (s_axi_araddr)
      `BCTME_ADDR_CTRL: next_rdata = {29'h0, internal_reset, standby, busy};
      `BCTME_ADDR_INSTR: next_rdata = {27'h0, instr};
      `BCTME_ADDR_OPER: next_rdata = {22'h0, operand};
      `BCTME_ADDR_STATE: next_rdata = {8'h0, pair_sel, pair_out, nib_out, acc, match_flag, carry_bit,
        rom_page_select};
      `BCTME_ADDR_PCSP: next_rdata = {9'h0, sp, ret_store, pc};
      `BCTME_ADDR_TIMER: next_rdata = {1'b0, timer_interval, 5'h0, timer_div_sel, timer};
      `BCTME_ADDR_INPUT: next_rdata = {20'h0, status_in, bank1_reg_0, bank0_reg_0};
      default: begin
        next_rresp = 2'b10;
      end
    endcase
  end

  // Address and data are latched apart so either channel may come first
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `BCTME_ADDR_CTRL, `BCTME_ADDR_INSTR, `BCTME_ADDR_OPER, `BCTME_ADDR_STATE, `BCTME_ADDR_INPUT:
            s_axi_bresp <= 2'b00;
          default:
            s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Execute strobe is ignored while busy or halted, so a call cannot restart midway
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      pc <= `BCTME_PC_RESET;
      ret_store <= `BCTME_PC_RESET;
      sp <= `BCTME_SP_RESET;
      carry_bit <= 1'b0;
      match_flag <= 1'b0;
      timer <= `BCTME_TIMER_RESET;
      timer_div_sel <= 1'b0;
      acc <= 4'h0;
      bank0_reg_0 <= 4'h0;
      bank1_reg_0 <= 4'h0;
      status_in <= 4'h0;
      rom_page_select <= 2'b00;
      instr <= 5'h00;
      operand <= 10'h000;
      pair_out <= 8'h00;
      pair_sel <= 4'h0;
      nib_out <= 4'h0;
      pend_timer <= 1'b0;
      busy <= 1'b0;
      rom_addr <= 10'h000;
      internal_reset <= 1'b0;
      standby <= 1'b0;
      release_select <= 4'h0;
    end else begin
      internal_reset <= 1'b0;
      if (wr_go) begin
        case (aw_addr)
          `BCTME_ADDR_CTRL: begin
            if (w_data[1])
              standby <= 1'b0;
            timer_div_sel <= w_data[2];
          end
          `BCTME_ADDR_INSTR: begin
            instr <= w_data[4:0];
          end
          `BCTME_ADDR_OPER: begin
            operand <= w_data[9:0];
          end
          `BCTME_ADDR_STATE: begin
            rom_page_select <= w_data[1:0];
            carry_bit <= w_data[2];
            match_flag <= w_data[3];
            acc <= w_data[7:4];
          end
          `BCTME_ADDR_INPUT: begin
            bank0_reg_0 <= w_data[3:0];
            bank1_reg_0 <= w_data[7:4];
            status_in <= w_data[11:8];
          end
          default: begin
          end
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (exec_go) begin
            case (instr)
              `BCTME_OP_JUMP: begin
                pc <= target;
              end
              `BCTME_OP_JUMPC: begin
                pc <= bctme_branch(carry_bit, target, pc_skip);
              end
              `BCTME_OP_JUMPNC: begin
                pc <= bctme_branch(!carry_bit, target, pc_skip);
              end
              `BCTME_OP_JUMPF: begin
                pc <= bctme_branch(match_flag, target, pc_skip);
              end
              `BCTME_OP_JUMPNF: begin
                pc <= bctme_branch(!match_flag, target, pc_skip);
              end
              // Stack wraps; the reset pulse tells the core its return address is lost
              `BCTME_OP_CALL: begin
                sp <= sp_inc[2:0];
                if (sp_carry)
                  internal_reset <= 1'b1;
                busy <= 1'b1;
                state <= ST_CALL2;
              end
              `BCTME_OP_EXIT: begin
                pc <= ret_store;
                sp <= sp_dec[2:0];
                if (sp_borrow)
                  internal_reset <= 1'b1;
              end
              `BCTME_OP_TBLPAIR, `BCTME_OP_TBLTIM: begin
                rom_addr <= table_addr;
                pend_timer <= (instr == `BCTME_OP_TBLTIM);
                // Pair zero is the table pointer itself, so a zero selector lands in pair one
                pair_sel <= (operand[3:0] == 4'h0) ? 4'h1 : operand[3:0];
                busy <= 1'b1;
                state <= ST_FETCH;
              end
              `BCTME_OP_RDTIM: begin
                nib_out <= timer_nib;
                acc <= timer_nib;
                carry_bit <= 1'b0;
                pc <= pc_next1;
              end
              `BCTME_OP_WRTIM: begin
                if (operand[0])
                  timer <= {acc, timer[5:2], 1'b0, timer[0]};
                else
                  timer <= {timer[9:6], acc, timer[1], 1'b0};
                pc <= pc_next1;
              end
              `BCTME_OP_LDTIM: begin
                timer <= bctme_timer_unscramble(operand);
                pc <= pc_skip;
              end
              `BCTME_OP_HALT: begin
                // Release conditions are kept for the wake logic outside this block
                standby <= 1'b1;
                release_select <= operand[3:0];
                pc <= pc_skip;
              end
              `BCTME_OP_STATREG: begin
                match_flag <= bctme_any_match(status_in, bank0_reg_0);
                pc <= pc_next1;
              end
              `BCTME_OP_STATIMM: begin
                match_flag <= bctme_any_match(status_in, operand[3:0]);
                pc <= pc_skip;
              end
              `BCTME_OP_CAF: begin
                carry_bit <= (acc == 4'hf);
                pc <= pc_next1;
              end
              default: begin
                pc <= pc_next1;
              end
            endcase
          end
        end
        // Second call cycle: store and PC move together while busy blocks execute
        ST_CALL2: begin
          ret_store <= pc_skip;
          pc <= target;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        // ROM word for the address set one cycle earlier is valid now
        ST_FETCH: begin
          if (pend_timer)
            timer <= rom_data;
          else
            pair_out <= rom_data[7:0];
          pc <= pc_next1;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: bctme_properties.sv
`timescale 1ns/100ps
`default_nettype none
module bctme_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic internal_reset,
  input wire logic standby,
  input wire logic [3:0] release_select,
  input wire logic [9:0] rom_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_r_stall; s_axi_rvalid && !s_axi_rready; endsequence
  property p_rlat; s_ar_taken |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer not one cycle after address");
  property p_rhold; s_r_stall |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped before rready");
  property p_rstab; s_r_stall |=> $stable(s_axi_rdata); endproperty
  a_rstab: assert property (p_rstab) else $error("read data moved while stalled");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped or changed");
  property p_rrise; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
  a_rrise: assert property (p_rrise) else $error("read answer without a request");
  property p_irst; internal_reset |=> !internal_reset; endproperty
  a_irst: assert property (p_irst) else $error("internal reset longer than one cycle");
  // Own disable, since the antecedent is the reset itself
  property p_quiet;
    disable iff (1'b0) !aresetn |=> !internal_reset && !standby && release_select == 4'h0 && rom_addr == 10'h000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs not cleared by reset");
  property p_rel; standby ##1 standby |-> $stable(release_select); endproperty
  a_rel: assert property (p_rel) else $error("release select moved in standby");
endmodule
bind bctme_core bctme_properties chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .internal_reset(internal_reset), .standby(standby),
  .release_select(release_select), .rom_addr(rom_addr));
`default_nettype wire

// File: branch_call_timer_misc_exec_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "bctme_regs.vh"
`define CK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin miscompares = miscompares + 1; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module branch_call_timer_misc_exec_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, dv = 0;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [9:0] rom_data = 0, rom_addr;
  logic awready, wready, bvalid, arready, rvalid, ireset, standby;
  logic [1:0] bresp, rresp;
  logic [3:0] rel;
  integer seed = 88080, miscompares = 0, n_checks = 0, nrst = 0, i, k, x, op, t, tk;
  integer pc = 0, sp = 0, stk = 0, tm = 0, cy = 0, mf = 0, acc = 0, pg = 0;
  always #2 aclk = ~aclk;
  // Word contents differ from the address so a swapped field shows up
  always @(rom_addr) rom_data <= rom_addr ^ 10'h2c5;
  always @(posedge aclk) if (ireset === 1'b1) nrst <= nrst + 1;
  bctme_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rom_data(rom_data), .rom_addr(rom_addr), .internal_reset(ireset),
    .standby(standby), .release_select(rel));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Response ready comes late at random so the slave must hold its answer
  task wr(input [4:0] a, input [31:0] v);
    begin
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
      @(posedge aclk);
      while (awvalid || wvalid) begin
        if (awready) awvalid <= 0;
        if (wready) wvalid <= 0;
        @(posedge aclk);
      end
      repeat ($random(seed) & 3) @(posedge aclk);
      bready <= 1;
      @(posedge aclk);
      while (!bvalid) @(posedge aclk);
      bready <= 0;
    end
  endtask
  task rd(input [4:0] a);
    begin
      araddr <= a; arvalid <= 1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 0;
      repeat ($random(seed) & 3) @(posedge aclk);
      rready <= 1;
      @(posedge aclk);
      while (!rvalid) @(posedge aclk);
      d = rdata;
      rready <= 0;
    end
  endtask
  task ex(input [4:0] c, input [9:0] o);
    begin
      wr(`BCTME_ADDR_OPER, {22'h0, o});
      wr(`BCTME_ADDR_INSTR, {27'h0, c});
      wr(`BCTME_ADDR_CTRL, {29'h0, dv, 2'b01});
      d = 1;
      for (x = 0; x < 20 && d[0]; x = x + 1) rd(`BCTME_ADDR_CTRL);
    end
  endtask
  task st;
    wr(`BCTME_ADDR_STATE, {24'h0, acc[3:0], mf[0], cy[0], pg[1:0]});
  endtask
  task sst;
    begin rd(`BCTME_ADDR_STATE); `CK(d[7:0], {acc[3:0], mf[0], cy[0], pg[1:0]}) end
  endtask
  task chkpc;
    begin rd(`BCTME_ADDR_PCSP); `CK(d[22:0], {sp[2:0], stk[9:0], pc[9:0]}) end
  endtask
  task tchk;
    begin rd(`BCTME_ADDR_TIMER); `CK(d[30:0], {15'((tm + 1) * (dv ? 16 : 8)), 5'h0, dv, tm[9:0]}) end
  endtask
  function [9:0] scr(input [9:0] a);
    scr = {a[9], a[7:4], a[8], a[3:0]};
  endfunction
  initial begin
    #200000;
    miscompares = miscompares + 1;
    test_done;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chkpc;
    tchk;
    $display("reset test done");
    for (i = 0; i < 30; i = i + 1) begin
      op = i % 6; cy = $random(seed) & 1; mf = $random(seed) & 1; acc = $random(seed) & 15;
      t = $random(seed) & 1023;
      st;
      ex(op[4:0], scr(t[9:0]));
      tk = op == 1 || (op == 2 && cy) || (op == 3 && !cy) || (op == 4 && mf) || (op == 5 && !mf);
      pc = (op == 0 ? pc + 1 : (tk ? t : pc + 2)) & 1023;
      chkpc;
      sst;
    end
    $display("jump test done");
    t = $random(seed) & 1023;
    ex(`BCTME_OP_CALL, scr(t[9:0]));
    stk = (pc + 2) & 1023; sp = 1; pc = t;
    chkpc;
    ex(`BCTME_OP_EXIT, 10'h000);
    pc = stk; sp = 0;
    chkpc;
    $display("call test done");
    for (i = 0; i < 4; i = i + 1) begin
      tm = $random(seed) & 1023; dv = i[0];
      ex(`BCTME_OP_LDTIM, {tm[1], tm[9:6], tm[0], tm[5:2]});
      tchk;
      acc = $random(seed) & 15; cy = 1;
      st;
      ex(`BCTME_OP_WRTIM, {9'h0, i[1]});
      tm = i[1] ? {acc[3:0], tm[5:2], 1'b0, tm[0]} : {tm[9:6], acc[3:0], tm[1], 1'b0};
      tchk;
      ex(`BCTME_OP_RDTIM, {9'h0, i[0]});
      acc = i[0] ? tm[9:6] : tm[5:2]; cy = 0;
      sst;
    end
    $display("timer test done");
    for (i = 0; i < 4; i = i + 1) begin
      pg = $random(seed) & 3; t = $random(seed) & 255; k = i * 4 + 3;
      st;
      wr(`BCTME_ADDR_INPUT, {24'h0, t[7:0]});
      ex(`BCTME_OP_TBLTIM, 10'h000);
      tm = {pg[1:0], t[7:0]} ^ 10'h2c5;
      tchk;
      ex(`BCTME_OP_TBLPAIR, {6'h0, k[3:0]});
      rd(`BCTME_ADDR_STATE);
      `CK(d[23:12], {k[3:0], tm[7:0]})
    end
    $display("table test done");
    for (i = 0; i < 8; i = i + 1) begin
      t = $random(seed) & 4095; op = $random(seed) & 15;
      wr(`BCTME_ADDR_INPUT, {20'h0, t[11:0]});
      if (i[0]) ex(`BCTME_OP_STATIMM, {6'h0, op[3:0]});
      else ex(`BCTME_OP_STATREG, 10'h000);
      mf = (t[11:8] & (i[0] ? op[3:0] : t[3:0])) != 0;
      sst;
    end
    for (i = 0; i < 16; i = i + 1) begin
      acc = i; cy = $random(seed) & 1;
      st;
      ex(`BCTME_OP_CAF, 10'h000);
      cy = i == 15;
      sst;
    end
    $display("status test done");
    t = $random(seed) & 15;
    ex(`BCTME_OP_HALT, t[9:0]);
    `CK({standby, rel}, {1'b1, t[3:0]})
    wr(`BCTME_ADDR_CTRL, 32'h2);
    @(posedge aclk);
    `CK(standby, 1'b0)
    ex(`BCTME_OP_EXIT, 10'h000);
    `CK(nrst, 1)
    repeat (8) ex(`BCTME_OP_CALL, 10'h000);
    `CK(nrst, 2)
    $display("stack test done");
    test_done;
  end
endmodule
`default_nettype wire
